// *** core/fspg_pkg.sv ***
// Purpose: shared constants and types for the flash self-program guard
// Assumes: byte-wide peripheral registers on a 16-bit address space
// Notes:   each offset and field position, and the status, protect, value and read-data reset values, is named once here

package fspg_pkg;

	// register byte addresses
	localparam logic [15:0] FSPG_ADDR_KEY    = 16'hffa0;
	localparam logic [15:0] FSPG_ADDR_STATUS = 16'hffa1;
	localparam logic [15:0] FSPG_ADDR_MODE   = 16'hffa2;

	// key value that opens an update of the mode control register
	localparam logic [7:0] FSPG_KEY_VALUE = 8'ha5;

	// byte-lane mask of a full 8-bit store
	localparam logic [7:0] FSPG_MASK_FULL = 8'hff;

	// mode control register layout
	localparam int FSPG_MODE_SEL_BIT = 0;
	localparam int FSPG_PROT_LSB     = 2;
	localparam int FSPG_PROT_W       = 5;

	// status register layout
	localparam int FSPG_ST_KEY_ERR = 0;
	localparam int FSPG_ST_VERIFY  = 1;
	localparam int FSPG_ST_AREA    = 2;
	localparam int FSPG_ST_W       = 3;

	// reset values
	localparam logic [FSPG_ST_W-1:0]   FSPG_STATUS_RESET = 3'h0;
	localparam logic [FSPG_PROT_W-1:0] FSPG_PROT_RESET   = 5'h00;
	localparam logic [7:0]             FSPG_VALUE_RESET  = 8'h00;
	localparam logic [7:0]             FSPG_RDATA_RESET  = 8'h00;

	// one register-port request
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  wmask;
		logic        wr;
		logic        rd;
	} fspg_bus_req_t;

	// result of one flash command, valid with done
	typedef struct packed {
		logic done;
		logic verify_fail;
		logic area_protected;
	} fspg_flash_res_t;

	// keyed update progress
	typedef enum logic [1:0] {
		FSPG_SEQ_IDLE    = 2'b00,
		FSPG_SEQ_KEYED   = 2'b01,
		FSPG_SEQ_VALUE   = 2'b10,
		FSPG_SEQ_INVERSE = 2'b11
	} fspg_seq_state_t;

	// flash command launched by halt
	typedef enum logic {
		FSPG_PROG_IDLE = 1'b0,
		FSPG_PROG_WAIT = 1'b1
	} fspg_prog_state_t;

endpackage

// *** core/fspg_key_seq.sv ***
// Purpose: checks the four-store keyed update of the mode control register
// Assumes: one store per cycle at most, all stores on clk
// Notes:   commit and key_error are combinational pulses in the cycle of the store; commit_value is held in a register

`timescale 1ns/1ps

module fspg_key_seq (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       store,
	input  wire logic       full_byte,
	input  wire logic       to_key,
	input  wire logic       to_mode,
	input  wire logic [7:0] wdata,
	output logic            commit,
	output logic [7:0]      commit_value,
	output logic            key_error
);

	fspg_pkg::fspg_seq_state_t state_reg;
	fspg_pkg::fspg_seq_state_t state_next;
	logic [7:0]                value_reg;
	logic                      mode_ok;

	// a partial store never counts as a step: the mode register takes bytes only
	assign mode_ok      = to_mode & full_byte;
	assign commit_value = value_reg;

	// step decode; any break drops back to idle so a new key is needed
	always_comb begin
		state_next = state_reg;
		commit     = 1'b0;
		key_error  = 1'b0;
		if (store) begin
			unique case (state_reg)
				fspg_pkg::FSPG_SEQ_IDLE: begin
					if (to_key) begin
						if (full_byte && wdata == fspg_pkg::FSPG_KEY_VALUE) begin
							state_next = fspg_pkg::FSPG_SEQ_KEYED;
						end else begin
							key_error = 1'b1;
						end
					end
				end
				fspg_pkg::FSPG_SEQ_KEYED: begin
					if (mode_ok) begin
						state_next = fspg_pkg::FSPG_SEQ_VALUE;
					end else begin
						key_error  = 1'b1;
						state_next = fspg_pkg::FSPG_SEQ_IDLE;
					end
				end
				fspg_pkg::FSPG_SEQ_VALUE: begin
					if (mode_ok && wdata == ~value_reg) begin
						state_next = fspg_pkg::FSPG_SEQ_INVERSE;
					end else begin
						key_error  = 1'b1;
						state_next = fspg_pkg::FSPG_SEQ_IDLE;
					end
				end
				fspg_pkg::FSPG_SEQ_INVERSE: begin
					state_next = fspg_pkg::FSPG_SEQ_IDLE;
					if (mode_ok && wdata == value_reg) begin
						commit = 1'b1;
					end else begin
						key_error = 1'b1;
					end
				end
			endcase
		end
	end

	// step state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= fspg_pkg::FSPG_SEQ_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// target value kept from the second step
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			value_reg <= fspg_pkg::FSPG_VALUE_RESET;
		end else if (store && mode_ok && state_reg == fspg_pkg::FSPG_SEQ_KEYED) begin
			value_reg <= wdata;
		end
	end

endmodule // fspg_key_seq

// *** core/fspg_guard.sv ***
// Purpose: mode control, keyed unlock and error status for flash self programming
// Assumes: cpu, flash sequencer and protect byte all run on clk
// Notes:   command, pointer and write buffer registers live elsewhere

`timescale 1ns/1ps

module fspg_guard #(
	parameter bit VERIFY_ON_PROTECT = 1'b1
) (
	input  wire logic                            clk,
	input  wire logic                            rst,
	input  wire fspg_pkg::fspg_bus_req_t         bus_req,
	output logic [7:0]                           bus_rdata,
	input  wire logic [fspg_pkg::FSPG_PROT_W-1:0] protect_byte_in,
	input  wire logic                            cpu_halt,
	input  wire fspg_pkg::fspg_flash_res_t       flash_res,
	output logic                                 prog_start,
	output logic                                 prog_busy,
	output logic                                 halt_release,
	output logic                                 self_program_select,
	output logic                                 fetch_all_allowed,
	output logic                                 irq_defer
);

	// decoded register-port traffic
	logic                              hit_key;
	logic                              hit_status;
	logic                              hit_mode;
	logic                              full_byte;
	logic                              store;

	// keyed update results
	logic                              seq_commit;
	logic [7:0]                        seq_value;
	logic                              seq_error;

	// mode control state
	logic                              mode_sel_reg;
	logic                              fetch_all_reg;
	logic                              irq_defer_reg;
	logic [fspg_pkg::FSPG_PROT_W-1:0]  prot_reg;
	logic                              prot_load_reg;

	// status flags and their set and clear terms
	logic [fspg_pkg::FSPG_ST_W-1:0]    status_reg;
	logic [fspg_pkg::FSPG_ST_W-1:0]    status_set;
	logic [fspg_pkg::FSPG_ST_W-1:0]    status_clr;

	// flash command sequencing
	fspg_pkg::fspg_prog_state_t        prog_state_reg;
	logic                              prog_start_reg;
	logic                              prog_busy_reg;
	logic                              halt_release_reg;
	logic                              cmd_done;

	// read path
	logic [7:0]                        rdata_reg;
	logic [7:0]                        rdata_next;
	logic [7:0]                        mode_view;
	logic [7:0]                        status_view;

	// address decode; every store on this port is a peripheral store
	assign hit_key    = (bus_req.addr == fspg_pkg::FSPG_ADDR_KEY);
	assign hit_status = (bus_req.addr == fspg_pkg::FSPG_ADDR_STATUS);
	assign hit_mode   = (bus_req.addr == fspg_pkg::FSPG_ADDR_MODE);
	assign full_byte  = (bus_req.wmask == fspg_pkg::FSPG_MASK_FULL);
	assign store      = bus_req.wr;

	// keyed update checker; it also watches stores to foreign registers
	fspg_key_seq u_key_seq (
		.clk          (clk),
		.rst          (rst),
		.store        (store),
		.full_byte    (full_byte),
		.to_key       (hit_key),
		.to_mode      (hit_mode),
		.wdata        (bus_req.wdata),
		.commit       (seq_commit),
		.commit_value (seq_value),
		.key_error    (seq_error)
	);

	// mode bit: only the fourth keyed store moves it, a broken
	// sequence leaves it untouched; cleared by reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_sel_reg <= 1'b0;
		end else if (seq_commit) begin
			mode_sel_reg <= seq_value[fspg_pkg::FSPG_MODE_SEL_BIT];
		end
	end

	// fetch permission tracks the mode bit but is its own flop
	// so the output needs no gate after the register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fetch_all_reg <= 1'b1;
		end else if (seq_commit) begin
			fetch_all_reg <= ~seq_value[fspg_pkg::FSPG_MODE_SEL_BIT];
		end
	end

	// interrupt deferral follows the mode bit in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_defer_reg <= 1'b0;
		end else if (seq_commit) begin
			irq_defer_reg <= seq_value[fspg_pkg::FSPG_MODE_SEL_BIT];
		end
	end

	// protect setting: async reset may only load a constant, so the
	// protect byte is caught by the first clock edge after release
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prot_reg      <= fspg_pkg::FSPG_PROT_RESET;
			prot_load_reg <= 1'b1;
		end else if (prot_load_reg) begin
			prot_reg      <= protect_byte_in;
			prot_load_reg <= 1'b0;
		end
	end

	// halt with the mode bit set launches the loaded command; the cpu
	// stays halted, so no stores arrive until the release pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prog_state_reg   <= fspg_pkg::FSPG_PROG_IDLE;
			prog_start_reg   <= 1'b0;
			prog_busy_reg    <= 1'b0;
			halt_release_reg <= 1'b0;
		end else begin
			prog_start_reg   <= 1'b0;
			halt_release_reg <= 1'b0;
			unique case (prog_state_reg)
				fspg_pkg::FSPG_PROG_IDLE: begin
					if (cpu_halt && mode_sel_reg) begin
						prog_state_reg <= fspg_pkg::FSPG_PROG_WAIT;
						prog_start_reg <= 1'b1;
						prog_busy_reg  <= 1'b1;
					end
				end
				fspg_pkg::FSPG_PROG_WAIT: begin
					if (flash_res.done) begin
						prog_state_reg   <= fspg_pkg::FSPG_PROG_IDLE;
						prog_busy_reg    <= 1'b0;
						halt_release_reg <= 1'b1;
					end
				end
			endcase
		end
	end

	// a done strobe outside a launched command is ignored
	assign cmd_done = flash_res.done && (prog_state_reg == fspg_pkg::FSPG_PROG_WAIT);

	// hardware set terms for each flag
	always_comb begin
		status_set = '0;
		status_set[fspg_pkg::FSPG_ST_KEY_ERR] = seq_error;
		status_set[fspg_pkg::FSPG_ST_VERIFY]  = cmd_done &&
			(flash_res.verify_fail ||
			(VERIFY_ON_PROTECT && flash_res.area_protected));
		status_set[fspg_pkg::FSPG_ST_AREA]    = cmd_done &&
			flash_res.area_protected;
	end

	// status flags: writing 0 clears, writing 1 keeps; a bit store
	// only touches the lane its mask selects; set beats clear
	genvar gi;
	generate
		for (gi = 0; gi < fspg_pkg::FSPG_ST_W; gi++) begin : g_flag
			assign status_clr[gi] = store && hit_status &&
				bus_req.wmask[gi] && !bus_req.wdata[gi];
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					status_reg[gi] <= fspg_pkg::FSPG_STATUS_RESET[gi];
				end else if (status_set[gi]) begin
					status_reg[gi] <= 1'b1;
				end else if (status_clr[gi]) begin
					status_reg[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// register views; protect bits read back the latched byte and the
	// unused positions read zero, writes never reach them
	always_comb begin
		mode_view = '0;
		mode_view[fspg_pkg::FSPG_MODE_SEL_BIT] = mode_sel_reg;
		mode_view[fspg_pkg::FSPG_PROT_LSB +: fspg_pkg::FSPG_PROT_W] = prot_reg;
		status_view = '0;
		status_view[fspg_pkg::FSPG_ST_W-1:0] = status_reg;
	end

	// read mux; key register is write-only and unmapped addresses read zero
	always_comb begin
		rdata_next = fspg_pkg::FSPG_RDATA_RESET;
		if (bus_req.rd) begin
			if (hit_mode) begin
				rdata_next = mode_view;
			end else if (hit_status) begin
				rdata_next = status_view;
			end
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= fspg_pkg::FSPG_RDATA_RESET;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// outputs, each straight from a flop
	assign bus_rdata           = rdata_reg;
	assign prog_start          = prog_start_reg;
	assign prog_busy           = prog_busy_reg;
	assign halt_release        = halt_release_reg;
	assign self_program_select = mode_sel_reg;
	assign fetch_all_allowed   = fetch_all_reg;
	assign irq_defer           = irq_defer_reg;

endmodule // fspg_guard

// *** dv/fspg_guard_sva.sv ***
// Purpose: concurrent checks on the ports of the flash self-program guard
// Assumes: single clock domain, reset rst asynchronous active high
// Notes:   bound to every fspg_guard instance at the foot of this file

`timescale 1ns/1ps

module fspg_guard_sva (
	input wire logic                            clk,
	input wire logic                            rst,
	input wire fspg_pkg::fspg_bus_req_t         bus_req,
	input wire logic [7:0]                      bus_rdata,
	input wire logic                            cpu_halt,
	input wire fspg_pkg::fspg_flash_res_t       flash_res,
	input wire logic                            prog_start,
	input wire logic                            prog_busy,
	input wire logic                            halt_release,
	input wire logic                            self_program_select,
	input wire logic                            fetch_all_allowed,
	input wire logic                            irq_defer
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// mode bit outputs must agree with each other at all times
	fetch_mode_a: assert property (fetch_all_allowed == !self_program_select)
		else $error("fetch permission not the inverse of the mode bit");
	irq_hold_a: assert property (irq_defer == self_program_select)
		else $error("interrupt deferral does not follow the mode bit");
	// a halt in self-program mode launches exactly one command
	halt_launch_a: assert property (cpu_halt && self_program_select && !prog_busy
		|=> prog_start && prog_busy) else $error("halt in mode did not launch");
	start_cause_a: assert property ($rose(prog_busy) |-> $past(cpu_halt)
		&& $past(self_program_select)) else $error("command started without halt");
	busy_hold_a: assert property (prog_busy && !flash_res.done |=> prog_busy
		&& !halt_release) else $error("busy dropped before completion");
	halt_end_a: assert property (prog_busy && flash_res.done |=> !prog_busy
		&& halt_release ##1 !halt_release) else $error("halt not released once");
	// the mode bit only moves on a store aimed at the mode register
	mode_keyed_a: assert property ($changed(self_program_select) |-> $past(bus_req.wr)
		&& $past(bus_req.addr) == fspg_pkg::FSPG_ADDR_MODE) else $error("mode moved unkeyed");
	status_top_a: assert property (bus_req.rd && bus_req.addr == fspg_pkg::FSPG_ADDR_STATUS
		|=> bus_rdata[7:3] == 5'h00) else $error("status upper bits not zero");
	mode_read_a: assert property (bus_req.rd && bus_req.addr == fspg_pkg::FSPG_ADDR_MODE
		|=> bus_rdata[7] == 1'b0 && bus_rdata[1] == 1'b0
		&& bus_rdata[0] == self_program_select) else $error("mode read wrong");
endmodule // fspg_guard_sva

bind fspg_guard fspg_guard_sva fspg_guard_sva_inst (
	.clk                 (clk),
	.rst                 (rst),
	.bus_req             (bus_req),
	.bus_rdata           (bus_rdata),
	.cpu_halt            (cpu_halt),
	.flash_res           (flash_res),
	.prog_start          (prog_start),
	.prog_busy           (prog_busy),
	.halt_release        (halt_release),
	.self_program_select (self_program_select),
	.fetch_all_allowed   (fetch_all_allowed),
	.irq_defer           (irq_defer)
);

// *** dv/test_fspg_guard.sv ***
// Purpose: directed self-checking bench for the flash self-program guard
// Assumes: bus strobes one cycle, read data valid the cycle after the read
// Notes:   protect byte input is held constant; its value is arbitrary

`timescale 1ns/1ps

`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] %s expected %h seen %h", n, e, g); end end

module test_fspg_guard;
	localparam logic [15:0] KY = fspg_pkg::FSPG_ADDR_KEY;
	localparam logic [15:0] ST = fspg_pkg::FSPG_ADDR_STATUS;
	localparam logic [15:0] MD = fspg_pkg::FSPG_ADDR_MODE;
	localparam logic [15:0] OT = 16'h0010;
	logic                              clk = 1'b0;
	logic                              rst = 1'b1;
	fspg_pkg::fspg_bus_req_t           bus_req = '0;
	logic [7:0]                        bus_rdata;
	logic [fspg_pkg::FSPG_PROT_W-1:0]  prot = 5'h15;
	logic                              cpu_halt = 1'b0;
	fspg_pkg::fspg_flash_res_t         flash_res = '0;
	logic                              prog_start, prog_busy, halt_release;
	logic                              sel, fetch_ok, irq_defer;
	int                                error_cnt = 0;
	int                                num_checks = 0;

	fspg_guard fspg_guard_inst (.clk(clk), .rst(rst), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .protect_byte_in(prot), .cpu_halt(cpu_halt),
		.flash_res(flash_res), .prog_start(prog_start), .prog_busy(prog_busy),
		.halt_release(halt_release), .self_program_select(sel),
		.fetch_all_allowed(fetch_ok), .irq_defer(irq_defer));

	// 200 MHz clock
	always #2.5 clk = ~clk;

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// strobes are left high so back-to-back stores never assign twice per edge
	task automatic st(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m = 8'hff);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, wmask: m, wr: 1'b1, rd: 1'b0};
	endtask
	task automatic idle;
		@(posedge clk);
		bus_req.wr <= 1'b0;
		bus_req.rd <= 1'b0;
		#1;
	endtask
	task automatic rd_chk(input string n, input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 8'h00, wmask: 8'h00, wr: 1'b0, rd: 1'b1};
		idle();
		`CHK(n, e, bus_rdata)
	endtask
	// every change opens with a fresh key store; the bench has no
	// interrupt sources, so the sequence can never be split by one
	task automatic keyed(input logic [7:0] v);
		st(KY, fspg_pkg::FSPG_KEY_VALUE);
		st(MD, v);
		st(MD, ~v);
		st(MD, v);
		idle();
		`CHK("mode bit", v[0], sel)
		`CHK("fetch", ~v[0], fetch_ok)
		`CHK("defer", v[0], irq_defer)
		rd_chk("mode rd", MD, {1'b0, prot, 1'b0, v[0]});
	endtask
	// broken sequence aimed at clearing the mode bit while it is set
	task automatic bad(input string n, input int c, input logic [15:0] a[4], input logic [7:0] d[4]);
		for (int i = 0; i < c; i++) st(a[i], d[i]);
		idle();
		rd_chk(n, ST, 8'h01);
		`CHK(n, 1'b1, sel)
		st(ST, 8'h00);
		idle();
	endtask
	// in self-program mode wait 16 us (3200 cycles) before the halt
	task automatic flash(input logic m, input logic [7:0] e);
		if (m) repeat (3200) @(posedge clk);
		@(posedge clk);
		cpu_halt <= 1'b1;
		@(posedge clk);
		cpu_halt <= 1'b0;
		#1 `CHK("start", m, prog_start)
		`CHK("busy", m, prog_busy)
		repeat (3) @(posedge clk);
		flash_res <= '{done: 1'b1, verify_fail: 1'b1, area_protected: 1'b1};
		@(posedge clk);
		flash_res <= '0;
		#1 `CHK("release", m, halt_release)
		`CHK("busy end", 1'b0, prog_busy)
		rd_chk("flash st", ST, e);
	endtask

	// watchdog well beyond the directed sequence
	initial begin
		#40000;
		error_cnt++;
		print_verdict();
	end

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 `CHK("reset mode", 1'b0, sel)
		`CHK("reset fetch", 1'b1, fetch_ok)
		rd_chk("reset st", ST, 8'h00);
		rd_chk("reset md", MD, {1'b0, prot, 2'b00});
		keyed(8'hff);
		st(ST, 8'h00);
		idle();
		flash(1'b1, 8'h06);
		st(ST, 8'h00);
		rd_chk("clear", ST, 8'h00);
		bad("key val", 1, '{KY, OT, OT, OT}, '{8'h5a, 0, 0, 0});
		bad("key key", 2, '{KY, KY, OT, OT}, '{8'ha5, 8'ha5, 0, 0});
		bad("step1", 2, '{KY, OT, OT, OT}, '{8'ha5, 0, 0, 0});
		bad("step2", 3, '{KY, MD, OT, OT}, '{8'ha5, 0, 0, 0});
		bad("inverse", 3, '{KY, MD, MD, OT}, '{8'ha5, 0, 8'hfe, 0});
		bad("final", 4, '{KY, MD, MD, MD}, '{8'ha5, 0, 8'hff, 8'h01});
		st(KY, 8'h00);
		st(ST, 8'hff);
		rd_chk("keep", ST, 8'h01);
		st(ST, 8'h00, 8'h01);
		rd_chk("bit clr", ST, 8'h00);
		keyed(8'h00);
		flash(1'b0, 8'h00);
		print_verdict();
	end
endmodule // test_fspg_guard
